// file: core/dsp_ctrl_pkg.sv
`default_nettype none
package dsp_ctrl_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_OPA = 8'h08;
  localparam logic [7:0] OFS_OPB = 8'h0C;
  localparam logic [7:0] OFS_CHAIN_LO = 8'h10;
  localparam logic [7:0] OFS_CHAIN_HI = 8'h14;
  localparam logic [7:0] OFS_ACC_LO = 8'h18;
  localparam logic [7:0] OFS_ACC_HI = 8'h1C;
  localparam logic [7:0] OFS_OUT_LO = 8'h20;
  localparam logic [7:0] OFS_OUT_HI = 8'h24;
  localparam logic [7:0] OFS_SHIFT = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // Control register bit positions
  localparam int CB_SIGNA = 0;
  localparam int CB_SIGNB = 1;
  localparam int CB_RND1 = 2;
  localparam int CB_RND2 = 3;
  localparam int CB_SAT1 = 4;
  localparam int CB_SAT2 = 5;
  localparam int CB_RELOAD = 6;
  localparam int CB_ZCHAIN = 7;
  localparam int CB_ZLOOP = 8;
  localparam int CB_ROT = 9;
  localparam int CB_SHR = 10;
  localparam int CTRL_W = 11;
  // Widths
  localparam int OP_W = 18;
  localparam int ACC_W = 44;
  localparam int SH_W = 32;
  localparam int SHAMT_W = 5;
  // Values after reset: loopback zeroed, group k on strobe k
  localparam logic [10:0] CTRL_RST = 11'h100;
  localparam logic [7:0] CLKSEL_RST = 8'hE4;
  // Default rounding and saturation placement
  localparam int RND_BITS_DEF = 16;
  localparam int SAT_BITS_DEF = 36;
endpackage : dsp_ctrl_pkg
`default_nettype wire

// file: core/dsp_ctrl_top.sv
// How it works
// - Two signedness bits qualify the multiplicand and multiplier operands.
// - Signedness bit 1 means two's complement, 0 means unsigned.
// - First-stage round enable rounds the product, otherwise passes it.
// - Second-stage round enable rounds the chain output, otherwise passes.
// - First-stage saturate enable clips the product result.
// - Second-stage saturate enable clips the chain output result.
// - With both enabled, saturation acts on the rounded value.
// - Reload low feeds the accumulator output back for accumulation.
// - Reload high forces feedback to zero, restarting from product.
// - Zero-chain control forces the incoming chain value to zero.
// - Zero-loopback control forces the loopback value to zero.
// - Rotate control selects rotation instead of a plain shift.
// - Right-shift select shifts right when 1, left when 0.
// - Four block-wide clocks; each register group picks one.
// - Four load enables; a register holds while its enable is low.
// - Four active-low clears asynchronously clear their registers.
// - Every control may change at run time and acts at once.
// - Arithmetic right shift fills with sign, logical with zeros.
// - A 44-bit accumulator is fed by the first-stage result.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// One pipeline register group with its own load and clear
module stage_reg #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic clear_n,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] q_r;
  } st_s;
  st_s st;
  st_s st_nxt;

  // Hold unless loaded
  always_comb begin
    st_nxt = st;
    if (load) begin
      st_nxt.q_r = d;
    end
  end

  // Clear wins asynchronously and holds zero until a later load
  always_ff @(posedge hclk or negedge clear_n) begin
    if (!clear_n) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  assign q = st.q_r;
endmodule : stage_reg

module dsp_ctrl_top #(
  parameter int RND_BITS = dsp_ctrl_pkg::RND_BITS_DEF,
  parameter int SAT_BITS = dsp_ctrl_pkg::SAT_BITS_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clk_strobe_0,
  input wire logic clk_strobe_1,
  input wire logic clk_strobe_2,
  input wire logic clk_strobe_3,
  input wire logic reg_load_enable_0,
  input wire logic reg_load_enable_1,
  input wire logic reg_load_enable_2,
  input wire logic reg_load_enable_3,
  input wire logic async_clear_n_0,
  input wire logic async_clear_n_1,
  input wire logic async_clear_n_2,
  input wire logic async_clear_n_3
);
  localparam int AW = dsp_ctrl_pkg::ACC_W;
  localparam int SW = dsp_ctrl_pkg::SH_W;

  typedef struct packed {
    logic ready_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] rdata_r;
    logic [dsp_ctrl_pkg::CTRL_W-1:0] ctrl_r;
    logic [7:0] clksel_r;
    logic [31:0] opa_r;
    logic [31:0] opb_r;
    logic [AW-1:0] chain_r;
  } st_s;
  st_s st;
  st_s st_nxt;

  logic [3:0] strobe;
  logic [3:0] ena;
  logic [3:0] clr_n;
  logic [3:0] ld;
  logic [63:0] in_q;
  logic [AW-1:0] m_d;
  logic [AW-1:0] m_q;
  logic [AW-1:0] acc_d;
  logic [AW-1:0] acc_q;
  logic [AW+SW-1:0] out_d;
  logic [AW+SW-1:0] out_q;
  logic ovf1;
  logic ovf2;

  assign strobe = {clk_strobe_3, clk_strobe_2, clk_strobe_1, clk_strobe_0};
  assign ena = {reg_load_enable_3, reg_load_enable_2,
                reg_load_enable_1, reg_load_enable_0};
  assign clr_n = {async_clear_n_3, async_clear_n_2,
                  async_clear_n_1, async_clear_n_0};

  // Each group loads on its selected strobe and its own enable
  for (genvar k = 0; k < 4; k++) begin : g_grp
    assign ld[k] = strobe[st.clksel_r[2*k +: 2]] & ena[k];
  end

  // Bus reset also clears every group; gating a clear is glitch-prone,
  // so the clear inputs must come straight from flops in the fabric
  stage_reg #(.W(64)) u_in (
    .hclk(hclk),
    .clear_n(hresetn & clr_n[0]),
    .load(ld[0]),
    .d({st.opa_r, st.opb_r}),
    .q(in_q)
  );
  stage_reg #(.W(AW)) u_mul (
    .hclk(hclk),
    .clear_n(hresetn & clr_n[1]),
    .load(ld[1]),
    .d(m_d),
    .q(m_q)
  );
  stage_reg #(.W(AW)) u_acc (
    .hclk(hclk),
    .clear_n(hresetn & clr_n[2]),
    .load(ld[2]),
    .d(acc_d),
    .q(acc_q)
  );
  stage_reg #(.W(AW+SW)) u_out (
    .hclk(hclk),
    .clear_n(hresetn & clr_n[3]),
    .load(ld[3]),
    .d(out_d),
    .q(out_q)
  );

  // Round to nearest integer by adding half an LSB, then drop residue
  function automatic logic [AW-1:0] rnd(input logic [AW-1:0] x);
    logic [AW-1:0] half;
    logic [AW-1:0] mask;
    half = {{(AW-1){1'b0}}, 1'b1} << (RND_BITS - 1);
    mask = ({{(AW-1){1'b0}}, 1'b1} << RND_BITS) - {{(AW-1){1'b0}}, 1'b1};
    rnd = (x + half) & ~mask;
  endfunction : rnd

  // Largest positive value that fits in SAT_BITS signed bits
  function automatic logic [AW-1:0] sat_max();
    sat_max = ({{(AW-1){1'b0}}, 1'b1} << (SAT_BITS - 1))
            - {{(AW-1){1'b0}}, 1'b1};
  endfunction : sat_max

  function automatic logic over(input logic [AW-1:0] x);
    over = ($signed(x) > $signed(sat_max()))
         | ($signed(x) < $signed(~sat_max()));
  endfunction : over

  // Asymmetric clip to the signed SAT_BITS range
  function automatic logic [AW-1:0] clip(input logic [AW-1:0] x);
    if ($signed(x) > $signed(sat_max())) begin
      clip = sat_max();
    end else if ($signed(x) < $signed(~sat_max())) begin
      clip = ~sat_max();
    end else begin
      clip = x;
    end
  endfunction : clip

  // Datapath; controls are read live so a change acts on the next load
  always_comb begin
    logic signed [dsp_ctrl_pkg::OP_W:0] ea;
    logic signed [dsp_ctrl_pkg::OP_W:0] eb;
    logic signed [2*dsp_ctrl_pkg::OP_W+1:0] prod;
    logic [AW-1:0] p1;
    logic [AW-1:0] fb;
    logic [AW-1:0] lb;
    logic [AW-1:0] cin;
    logic [AW-1:0] c2;
    logic [SW-1:0] op;
    logic [dsp_ctrl_pkg::SHAMT_W-1:0] n;
    logic [2*SW-1:0] dbl;
    logic [SW-1:0] sh;
    logic [dsp_ctrl_pkg::CTRL_W-1:0] c;
    dbl = '0;
    sh = '0;
    c = st.ctrl_r;
    ea = {c[dsp_ctrl_pkg::CB_SIGNA] & in_q[32+17], in_q[32 +: 18]};
    eb = {c[dsp_ctrl_pkg::CB_SIGNB] & in_q[17], in_q[17:0]};
    prod = ea * eb;
    p1 = {{(AW-38){prod[37]}}, prod};
    if (c[dsp_ctrl_pkg::CB_RND1]) begin
      p1 = rnd(p1);
    end
    ovf1 = over(p1);
    if (c[dsp_ctrl_pkg::CB_SAT1]) begin
      p1 = clip(p1);
    end
    m_d = p1;
    // Accumulator: feedback or zero, plus optional loopback
    fb = c[dsp_ctrl_pkg::CB_RELOAD] ? '0 : acc_q;
    lb = c[dsp_ctrl_pkg::CB_ZLOOP] ? '0 : out_q[SW +: AW];
    acc_d = m_q + fb + lb;
    // Chain output stage
    cin = c[dsp_ctrl_pkg::CB_ZCHAIN] ? '0 : st.chain_r;
    c2 = acc_q + cin;
    if (c[dsp_ctrl_pkg::CB_RND2]) begin
      c2 = rnd(c2);
    end
    ovf2 = over(c2);
    if (c[dsp_ctrl_pkg::CB_SAT2]) begin
      c2 = clip(c2);
    end
    // Shifter on the 32-bit operand A, amount in operand B
    op = in_q[32 +: SW];
    n = in_q[dsp_ctrl_pkg::SHAMT_W-1:0];
    if (c[dsp_ctrl_pkg::CB_ROT]) begin
      if (c[dsp_ctrl_pkg::CB_SHR]) begin
        dbl = {op, op} >> n;
        sh = dbl[SW-1:0];
      end else begin
        dbl = {op, op} << n;
        sh = dbl[2*SW-1:SW];
      end
    end else if (c[dsp_ctrl_pkg::CB_SHR]) begin
      if (c[dsp_ctrl_pkg::CB_SIGNA]) begin
        sh = $unsigned($signed(op) >>> n);
      end else begin
        sh = op >> n;
      end
    end else begin
      sh = op << n;
    end
    out_d = {c2, sh};
  end

  // Register read mux, all unmapped offsets read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    if (a == dsp_ctrl_pkg::OFS_CTRL) begin
      rd_mux = {21'h000000, st.ctrl_r};
    end else if (a == dsp_ctrl_pkg::OFS_CLKSEL) begin
      rd_mux = {24'h000000, st.clksel_r};
    end else if (a == dsp_ctrl_pkg::OFS_OPA) begin
      rd_mux = st.opa_r;
    end else if (a == dsp_ctrl_pkg::OFS_OPB) begin
      rd_mux = st.opb_r;
    end else if (a == dsp_ctrl_pkg::OFS_CHAIN_LO) begin
      rd_mux = st.chain_r[31:0];
    end else if (a == dsp_ctrl_pkg::OFS_CHAIN_HI) begin
      rd_mux = {20'h00000, st.chain_r[AW-1:32]};
    end else if (a == dsp_ctrl_pkg::OFS_ACC_LO) begin
      rd_mux = acc_q[31:0];
    end else if (a == dsp_ctrl_pkg::OFS_ACC_HI) begin
      rd_mux = {20'h00000, acc_q[AW-1:32]};
    end else if (a == dsp_ctrl_pkg::OFS_OUT_LO) begin
      rd_mux = out_q[SW +: 32];
    end else if (a == dsp_ctrl_pkg::OFS_OUT_HI) begin
      rd_mux = {20'h00000, out_q[AW+SW-1:SW+32]};
    end else if (a == dsp_ctrl_pkg::OFS_SHIFT) begin
      rd_mux = out_q[SW-1:0];
    end else if (a == dsp_ctrl_pkg::OFS_STATUS) begin
      rd_mux = {28'h0000000, ld[3], ld[2], ovf2, ovf1};
    end else begin
      rd_mux = 32'h00000000;
    end
  endfunction : rd_mux

  // Bus slave: zero wait states, writes land in the data phase
  always_comb begin
    logic take;
    take = hsel & hready & htrans[1];
    st_nxt = st;
    st_nxt.ready_r = 1'b1;
    st_nxt.wr_pend_r = take & hwrite;
    if (take) begin
      st_nxt.addr_r = haddr[7:0];
    end
    if (take && !hwrite) begin
      st_nxt.rdata_r = rd_mux(haddr[7:0]);
    end
    if (st.wr_pend_r) begin
      if (st.addr_r == dsp_ctrl_pkg::OFS_CTRL) begin
        st_nxt.ctrl_r = hwdata[dsp_ctrl_pkg::CTRL_W-1:0];
      end else if (st.addr_r == dsp_ctrl_pkg::OFS_CLKSEL) begin
        st_nxt.clksel_r = hwdata[7:0];
      end else if (st.addr_r == dsp_ctrl_pkg::OFS_OPA) begin
        st_nxt.opa_r = hwdata;
      end else if (st.addr_r == dsp_ctrl_pkg::OFS_OPB) begin
        st_nxt.opb_r = hwdata;
      end else if (st.addr_r == dsp_ctrl_pkg::OFS_CHAIN_LO) begin
        st_nxt.chain_r[31:0] = hwdata;
      end else if (st.addr_r == dsp_ctrl_pkg::OFS_CHAIN_HI) begin
        st_nxt.chain_r[AW-1:32] = hwdata[AW-33:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{ready_r: 1'b0, wr_pend_r: 1'b0, addr_r: 8'h00,
              rdata_r: 32'h00000000, ctrl_r: dsp_ctrl_pkg::CTRL_RST,
              clksel_r: dsp_ctrl_pkg::CLKSEL_RST, opa_r: 32'h00000000,
              opb_r: 32'h00000000, chain_r: 44'h00000000000};
    end else begin
      st <= st_nxt;
    end
  end

  assign hrdata = st.rdata_r;
  assign hreadyout = st.ready_r;
  assign hresp = 1'b0; // Always OKAY; a constant needs no flop
endmodule : dsp_ctrl_top
`default_nettype wire

// file: sim/fabric_model.sv
`timescale 1ns/100ps
`default_nettype none

// Fabric side of the block: block clocks, load enables and clears
module fabric_model (
  input wire logic hclk,
  input wire logic slow,
  input wire logic [3:0] en_req,
  input wire logic [3:0] clr_req_n,
  output logic [3:0] strobe,
  output logic [3:0] en,
  output logic [3:0] clr_n
);
  // Changes land just after an edge, like real fabric registers
  // Slow mode gaps each block clock on alternate edges
  always_ff @(posedge hclk) begin
    strobe <= slow ? ~strobe : 4'hF;
    en <= en_req;
    clr_n <= clr_req_n;
  end
endmodule : fabric_model

`default_nettype wire

// file: sim/dsp_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the top ports only
module dsp_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reg_load_enable_3,
  input wire logic async_clear_n_2,
  input wire logic async_clear_n_3
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd;
  // Read taken in its address phase
  assign rd = hsel && hready && htrans[1] && !hwrite;
  sequence rd_at(logic [7:0] a);
    rd && haddr[7:0] == a;
  endsequence
  sequence idle3;
    !reg_load_enable_3 && async_clear_n_3;
  endsequence
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_NO_WAIT: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  AST_UNMAPPED: assert property (rd && haddr[7:0] > 8'h2C |=> hrdata == 0)
    else $error("unmapped read not zero");
  AST_HOLD_DATA: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_CLR_ACC: assert property (
    rd_at(dsp_ctrl_pkg::OFS_ACC_LO) ##0 !async_clear_n_2 |=> hrdata == 0)
    else $error("cleared accumulator not zero");
  AST_CLR_OUT: assert property (
    !async_clear_n_3 ##1 rd_at(dsp_ctrl_pkg::OFS_OUT_LO) |=> hrdata == 0)
    else $error("output nonzero right after clear");
  AST_HI_ZERO: assert property (
    rd_at(dsp_ctrl_pkg::OFS_OUT_HI) |=> hrdata[31:12] == 20'h0)
    else $error("output upper bits beyond 44 set");
  AST_HOLD_OUT: assert property (
    (rd_at(dsp_ctrl_pkg::OFS_OUT_LO) ##0 idle3 [*2])
    ##1 rd_at(dsp_ctrl_pkg::OFS_OUT_LO) |=> hrdata == $past(hrdata, 2))
    else $error("output changed while its load was off");
endmodule : dsp_ctrl_chk

bind dsp_ctrl_top dsp_ctrl_chk u_dsp_ctrl_chk (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .reg_load_enable_3, .async_clear_n_2, .async_clear_n_3);

`default_nettype wire

// file: sim/dsp_block_dynamic_controls_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dsp_block_dynamic_controls_tb;
  typedef struct packed {
    logic [10:0] c;
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0] k;
    logic [31:0] e;
  } row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic [3:0] en_req = 4'hF;
  logic [3:0] clr_req_n = 4'hF;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic hreadyout;
  logic hresp;
  logic [3:0] strobe;
  logic [3:0] en;
  logic [3:0] clr_n;
  int err_count = 0;
  int n_compared = 0;
  // Kind 0 reads the low output word, 1 the high word, 2 the shifter
  // Rounding drops 16 bits half-up; saturation clips to signed 36 bits
  row_s rows [21] = '{
    '{11'h1C3, 32'h3FFFF, 32'h2, 2'h0, 32'hFFFFFFFE},
    '{11'h1C3, 32'h3FFFF, 32'h2, 2'h1, 32'hFFF},
    '{11'h1C0, 32'h3FFFF, 32'h2, 2'h0, 32'h7FFFE},
    '{11'h1C1, 32'h3FFFF, 32'h2, 2'h0, 32'hFFFFFFFE},
    '{11'h1C2, 32'h3FFFF, 32'h3FFFE, 2'h0, 32'hFFF80002},
    '{11'h1C2, 32'h3FFFF, 32'h3FFFE, 2'h1, 32'hFFF},
    '{11'h1C0, 32'h3FFFF, 32'h3FFFF, 2'h1, 32'hF},
    '{11'h1D0, 32'h3FFFF, 32'h3FFFF, 2'h1, 32'h7},
    '{11'h1D0, 32'h3FFFF, 32'h3FFFF, 2'h0, 32'hFFFFFFFF},
    '{11'h140, 32'h3, 32'h2, 2'h0, 32'hB},
    '{11'h1C0, 32'hAABBCCDD, 32'h8, 2'h2, 32'hBBCCDD00},
    '{11'h5C0, 32'hAABBCCDD, 32'h8, 2'h2, 32'h00AABBCC},
    '{11'h5C1, 32'hAABBCCDD, 32'h8, 2'h2, 32'hFFAABBCC},
    '{11'h3C0, 32'hAABBCCDD, 32'h8, 2'h2, 32'hBBCCDDAA},
    '{11'h7C0, 32'hAABBCCDD, 32'h8, 2'h2, 32'hDDAABBCC},
    '{11'h1C4, 32'h18000, 32'h1, 2'h0, 32'h20000},
    '{11'h1C4, 32'h17FFF, 32'h1, 2'h0, 32'h10000},
    '{11'h1C8, 32'h18000, 32'h1, 2'h0, 32'h20000},
    '{11'h1E0, 32'h3FFFF, 32'h3FFFF, 2'h1, 32'h7},
    '{11'h1D4, 32'h3FF00, 32'h20080, 2'h1, 32'h7},
    '{11'h1E8, 32'h3FF00, 32'h20080, 2'h1, 32'h7}};

  always #2 hclk = ~hclk;

  dsp_ctrl_top u_dsp_ctrl_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_strobe_0(strobe[0]),
    .clk_strobe_1(strobe[1]), .clk_strobe_2(strobe[2]),
    .clk_strobe_3(strobe[3]), .reg_load_enable_0(en[0]),
    .reg_load_enable_1(en[1]), .reg_load_enable_2(en[2]),
    .reg_load_enable_3(en[3]), .async_clear_n_0(clr_n[0]),
    .async_clear_n_1(clr_n[1]), .async_clear_n_2(clr_n[2]),
    .async_clear_n_3(clr_n[3]));

  fabric_model u_fabric_model (.hclk(hclk), .slow(slow), .en_req(en_req),
    .clr_req_n(clr_req_n), .strobe(strobe), .en(en), .clr_n(clr_n));

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask : tick

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus hang", $time);
      wrap_up();
    end
  endtask : wait_rdy

  // One single AHB transfer; read data is taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    n_compared++;
    if (rv !== e) begin
      err_count++;
      $display("[ERR] %0t addr %h got %h exp %h", $time, a, rv, e);
    end
  endtask : rd_chk

  // Four edges fill the pipe; six leave margin, slow mode needs double
  task automatic run_row(input int i);
    xfer(1'b1, dsp_ctrl_pkg::OFS_OPA, rows[i].a);
    xfer(1'b1, dsp_ctrl_pkg::OFS_OPB, rows[i].b);
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, {21'h0, rows[i].c});
    tick(slow ? 12 : 6);
    rd_chk(rows[i].k == 2'h0 ? dsp_ctrl_pkg::OFS_OUT_LO :
           rows[i].k == 2'h1 ? dsp_ctrl_pkg::OFS_OUT_HI :
           dsp_ctrl_pkg::OFS_SHIFT, rows[i].e);
  endtask : run_row

  initial begin
    tick(3);
    hresetn <= 1'b1;
    tick(1);
    rd_chk(dsp_ctrl_pkg::OFS_CTRL, 32'h100);
    rd_chk(dsp_ctrl_pkg::OFS_CLKSEL, 32'hE4);
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    rd_chk(8'h30, 32'h0);
    $display("reset test done");
    xfer(1'b1, dsp_ctrl_pkg::OFS_CHAIN_LO, 32'h5);
    foreach (rows[i]) run_row(i);
    slow <= 1'b1;
    run_row(0);
    slow <= 1'b0;
    $display("row test done");
    // Hold the accumulator, then add exactly one more product
    xfer(1'b1, dsp_ctrl_pkg::OFS_OPA, 32'h3);
    xfer(1'b1, dsp_ctrl_pkg::OFS_OPB, 32'h2);
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, 32'h1C0);
    tick(6);
    en_req <= 4'h0;
    tick(2);
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, 32'h180);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'h6);
    rd_chk(dsp_ctrl_pkg::OFS_OUT_LO, 32'h6);
    rd_chk(dsp_ctrl_pkg::OFS_OUT_LO, 32'h6);
    en_req <= 4'h4;
    tick(1);
    en_req <= 4'h0;
    tick(3);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'hC);
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, 32'h1C0);
    en_req <= 4'h4;
    tick(1);
    en_req <= 4'h0;
    tick(3);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'h6);
    // Loopback open: the held output word is added into the accumulator
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, 32'h0C0);
    en_req <= 4'h4;
    tick(1);
    en_req <= 4'h0;
    tick(3);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'hC);
    xfer(1'b1, dsp_ctrl_pkg::OFS_CTRL, 32'h1C0);
    $display("accumulate test done");
    // Clear every group while loads are off
    clr_req_n <= 4'h0;
    tick(2);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'h0);
    rd_chk(dsp_ctrl_pkg::OFS_OUT_LO, 32'h0);
    clr_req_n <= 4'hF;
    tick(2);
    rd_chk(dsp_ctrl_pkg::OFS_OUT_LO, 32'h0);
    // Only the later groups load: a stale input or product would show here
    en_req <= 4'hC;
    tick(3);
    rd_chk(dsp_ctrl_pkg::OFS_SHIFT, 32'h0);
    rd_chk(dsp_ctrl_pkg::OFS_ACC_LO, 32'h0);
    en_req <= 4'hF;
    tick(6);
    rd_chk(dsp_ctrl_pkg::OFS_OUT_LO, 32'h6);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    rd_chk(dsp_ctrl_pkg::OFS_CTRL, 32'h100);
    $display("clear test done");
    wrap_up();
  end
endmodule : dsp_block_dynamic_controls_tb

`default_nettype wire
